// [rtl/tws_pkg.sv]
package tws_pkg;
  // ----------------------------------------
  // Addresses
  // ----------------------------------------
  localparam logic [7:0] WRITE_SLAVE_ADDRESS_0 = 8'h70;
  localparam logic [7:0] WRITE_SLAVE_ADDRESS_1 = 8'h72;
  localparam logic [7:0] READ_SLAVE_ADDRESS_0 = 8'h71;
  localparam logic [7:0] READ_SLAVE_ADDRESS_1 = 8'h73;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 20000000;
  localparam int LINK_HALF_NS = 2500;
  localparam int LINK_HALF_CYCLES = LINK_HALF_NS / (1000000000 / CLOCK_HZ);
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] SYNC_INIT = 3'h7;
endpackage

// [rtl/tws_if.sv]
`timescale 1ns/1ps
interface tws_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // Open-drain wired line with pull-up
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o,
    output sda_host_oe);
endinterface

// [rtl/tws_device.sv]
`timescale 1ns/1ps
module tws_device (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link
  tws_if.device link,
  // Address pair strap
  input wire logic addr_sel,
  // Register side
  output logic wr_strobe,
  output logic [7:0] reg_index,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_INDEX = 4'b0100,
    ST_DATA = 4'b1000
  } tws_dst_t;
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_q;
    logic sda_q;
    tws_dst_t st;
    logic reading;
    logic acking;
    logic drive_low;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] index;
    logic [7:0] wdata;
    logic wr;
  } tws_dstate_t;
  tws_dstate_t s_reg, s_next;
  logic scl_f, sda_f, scl_rise, scl_fall, start_c, stop_c, wmatch, rmatch;
  always_comb begin
    s_next = s_reg;
    s_next.scl_sync = {s_reg.scl_sync[1:0], link.scl};
    s_next.sda_sync = {s_reg.sda_sync[1:0], link.sda};
    s_next.wr = 1'b0;
    // Filtered levels, update only when stages 2 and 3 agree
    scl_f = (s_reg.scl_sync[1] == s_reg.scl_sync[2]) ? s_reg.scl_sync[2] : s_reg.scl_q;
    sda_f = (s_reg.sda_sync[1] == s_reg.sda_sync[2]) ? s_reg.sda_sync[2] : s_reg.sda_q;
    s_next.scl_q = scl_f;
    s_next.sda_q = sda_f;
    scl_rise = scl_f && !s_reg.scl_q;
    scl_fall = !scl_f && s_reg.scl_q;
    start_c = scl_f && s_reg.scl_q && !sda_f && s_reg.sda_q;
    stop_c = scl_f && s_reg.scl_q && sda_f && !s_reg.sda_q;
    wmatch = s_reg.shift == (addr_sel ? tws_pkg::WRITE_SLAVE_ADDRESS_1
      : tws_pkg::WRITE_SLAVE_ADDRESS_0);
    rmatch = s_reg.shift == (addr_sel ? tws_pkg::READ_SLAVE_ADDRESS_1
      : tws_pkg::READ_SLAVE_ADDRESS_0);
    if (start_c) begin
      s_next.st = ST_ADDR;
      s_next.bitn = '0;
      s_next.reading = 1'b0;
      s_next.acking = 1'b0;
      s_next.drive_low = 1'b0;
    end else if (stop_c) begin
      s_next.st = ST_IDLE;
      s_next.drive_low = 1'b0;
    end else if (s_reg.st != ST_IDLE) begin
      if (scl_rise && !s_reg.acking && !s_reg.reading) begin
        s_next.shift = {s_reg.shift[6:0], sda_f};
        s_next.bitn = s_reg.bitn + 4'h1;
      end
      if (scl_rise && s_reg.reading && s_reg.acking && sda_f) begin
        s_next.st = ST_IDLE;
      end
      if (scl_fall) begin
        if (s_reg.acking) begin
          s_next.acking = 1'b0;
          s_next.bitn = '0;
          s_next.drive_low = 1'b0;
          if (s_reg.reading) begin
            s_next.shift = rd_data;
            s_next.drive_low = !rd_data[7];
            s_next.bitn = 4'h1;
          end
        end else if (s_reg.reading) begin
          if (s_reg.bitn == tws_pkg::ACK_SLOT) begin
            s_next.acking = 1'b1;
            s_next.drive_low = 1'b0;
          end else begin
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.drive_low = !s_reg.shift[6];
            s_next.bitn = s_reg.bitn + 4'h1;
          end
        end else if (s_reg.bitn == tws_pkg::ACK_SLOT) begin
          s_next.acking = 1'b1;
          unique case (s_reg.st)
            ST_ADDR: begin
              if (wmatch) begin
                s_next.drive_low = 1'b1;
                s_next.st = ST_INDEX;
              end else if (rmatch) begin
                s_next.drive_low = 1'b1;
                s_next.reading = 1'b1;
                s_next.st = ST_DATA;
              end else begin
                s_next.st = ST_IDLE;
                s_next.acking = 1'b0;
              end
            end
            ST_INDEX: begin
              s_next.index = s_reg.shift;
              s_next.drive_low = 1'b1;
              s_next.st = ST_DATA;
            end
            ST_DATA: begin
              s_next.wdata = s_reg.shift;
              s_next.wr = 1'b1;
              s_next.drive_low = 1'b1;
            end
            default: s_next.st = ST_IDLE;
          endcase
        end
      end
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{scl_sync: tws_pkg::SYNC_INIT, sda_sync: tws_pkg::SYNC_INIT, scl_q: 1'b1,
        sda_q: 1'b1, st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = s_reg.drive_low;
  assign wr_strobe = s_reg.wr;
  assign reg_index = s_reg.index;
  assign wr_data = s_reg.wdata;
endmodule

// [rtl/tws_host.sv]
`timescale 1ns/1ps
module tws_host #(
  parameter int HALF = tws_pkg::LINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link
  tws_if.host link,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_index,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Result
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  typedef enum logic [6:0] {
    HS_IDLE = 7'b0000001,
    HS_START = 7'b0000010,
    HS_BIT = 7'b0000100,
    HS_ACK = 7'b0001000,
    HS_RSTA = 7'b0010000,
    HS_STOP = 7'b0100000,
    HS_DONE = 7'b1000000
  } tws_hst_t;
  typedef struct packed {
    tws_hst_t st;
    logic [1:0] phase;
    logic [15:0] cnt;
    logic [1:0] byten;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic scl;
    logic sda;
    logic rd;
    logic [7:0] addr;
    logic [7:0] index;
    logic [7:0] data;
    logic [7:0] rdat;
    logic nak;
    logic dn;
    logic [2:0] sda_sync;
  } tws_hstate_t;
  tws_hstate_t s_reg, s_next;
  logic tick, sda_in, rx_byte;
  always_comb begin
    s_next = s_reg;
    s_next.dn = 1'b0;
    s_next.sda_sync = {s_reg.sda_sync[1:0], link.sda};
    sda_in = s_reg.sda_sync[2];
    tick = s_reg.cnt == 16'(HALF - 1);
    s_next.cnt = tick ? '0 : s_reg.cnt + 16'h1;
    rx_byte = s_reg.rd && s_reg.byten == 2'h3;
    if (s_reg.st == HS_IDLE) begin
      s_next.cnt = '0;
      if (cmd_valid) begin
        s_next.rd = cmd_read;
        s_next.addr = {cmd_addr[7:1], 1'b0};
        s_next.index = cmd_index;
        s_next.data = cmd_data;
        s_next.nak = 1'b0;
        s_next.st = HS_START;
        s_next.phase = '0;
      end
    end else if (tick) begin
      s_next.phase = s_reg.phase + 2'h1;
      unique case (s_reg.st)
        HS_START, HS_RSTA: begin
          // Raise both, then pull data while clock high, then clock low
          unique case (s_reg.phase)
            2'h0: s_next.sda = 1'b1;
            2'h1: s_next.scl = 1'b1;
            2'h2: s_next.sda = 1'b0;
            default: begin
              s_next.scl = 1'b0;
              s_next.st = HS_BIT;
              s_next.bitn = '0;
              // Read address is the third byte; the fourth is the one received
              s_next.byten = (s_reg.st == HS_RSTA) ? 2'h2 : 2'h0;
              s_next.shift = (s_reg.st == HS_RSTA) ? {s_reg.addr[7:1], 1'b1} : s_reg.addr;
            end
          endcase
        end
        HS_BIT: begin
          unique case (s_reg.phase)
            2'h0: s_next.sda = rx_byte ? 1'b1 : s_reg.shift[7];
            2'h1: s_next.scl = 1'b1;
            2'h2: s_next.shift = {s_reg.shift[6:0], sda_in};
            default: begin
              s_next.scl = 1'b0;
              s_next.phase = '0;
              s_next.bitn = s_reg.bitn + 4'h1;
              if (s_reg.bitn == tws_pkg::LAST_BIT) begin
                s_next.st = HS_ACK;
                if (rx_byte) begin
                  s_next.rdat = s_reg.shift;
                end
              end
            end
          endcase
        end
        HS_ACK: begin
          unique case (s_reg.phase)
            2'h0: s_next.sda = 1'b1;
            2'h1: s_next.scl = 1'b1;
            2'h2: begin
              if (!rx_byte && sda_in) begin
                s_next.nak = 1'b1;
              end
            end
            default: begin
              s_next.scl = 1'b0;
              s_next.phase = '0;
              s_next.bitn = '0;
              s_next.byten = s_reg.byten + 2'h1;
              if (s_reg.nak || rx_byte || (!s_reg.rd && s_reg.byten == 2'h2)) begin
                s_next.st = HS_STOP;
              end else if (s_reg.rd && s_reg.byten == 2'h1) begin
                s_next.st = HS_RSTA;
              end else begin
                s_next.st = HS_BIT;
                s_next.shift = (s_reg.byten == 2'h0) ? s_reg.index : s_reg.data;
              end
            end
          endcase
        end
        HS_STOP: begin
          unique case (s_reg.phase)
            2'h0: s_next.sda = 1'b0;
            2'h1: s_next.scl = 1'b1;
            2'h2: s_next.sda = 1'b1;
            default: s_next.st = HS_DONE;
          endcase
        end
        HS_DONE: begin
          s_next.dn = 1'b1;
          s_next.st = HS_IDLE;
        end
        default: s_next.st = HS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: HS_IDLE, scl: 1'b1, sda: 1'b1, sda_sync: tws_pkg::SYNC_INIT,
        default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  // Open-drain: drive only lows
  assign link.scl_o = 1'b0;
  assign link.scl_oe = !s_reg.scl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = !s_reg.sda;
  assign cmd_ready = s_reg.st == HS_IDLE;
  assign done = s_reg.dn;
  assign nack = s_reg.nak;
  assign rd_data = s_reg.rdat;
endmodule

// [bench/tws_props.sv]
`timescale 1ns/1ps
module tws_props (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  // ----------------------------------------
  // Frame tracker
  // ----------------------------------------
  logic scl_q, sda_q, hit, rd;
  logic [3:0] bitn;
  logic [2:0] byten;
  logic [7:0] sh;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire ack = rise && bitn == 4'h8;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // Idle lines are high, so no false edge right after reset
      {scl_q, sda_q} <= 2'h3;
      {hit, rd, bitn, byten, sh} <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bitn <= 4'h0;
        byten <= 3'h0;
        hit <= 1'b0;
      end else if (ack) begin
        bitn <= 4'h0;
        byten <= byten + 3'h1;
        if (byten == 3'h0) begin
          hit <= !sda;
          rd <= sh[0];
        end
      end else if (rise) begin
        sh <= {sh[6:0], sda};
        bitn <= bitn + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_dev_drives_low: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data high");
  a_host_drives_low: assert property (sda_host_oe |-> !sda_host_o)
    else $error("host drives data high");
  a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device changed data while clock high");
  a_ack_known_addr: assert property (ack && byten == 3'h0 && !sda |-> sh[7:2] == 6'h1C)
    else $error("foreign address acknowledged");
  a_dev_acks_bytes: assert property (ack && byten != 3'h0 && hit && !rd |-> sda_dev_oe)
    else $error("byte not acknowledged");
  a_no_ack_at_end: assert property (ack && byten == 3'h1 && hit && rd |-> !sda_dev_oe)
    else $error("device pulled final not-acknowledge");
  a_quiet_foreign: assert property (byten != 3'h0 && !hit |-> !sda_dev_oe)
    else $error("unaddressed device drove data");
  a_host_free_ack: assert property (ack |-> !sda_host_oe)
    else $error("host held data in acknowledge slot");
  a_host_quiet_rd: assert property (rd && hit && byten == 3'h1 |-> !sda_host_oe)
    else $error("host drove data during read byte");
endmodule

// [bench/i2c_register_access_slave_tb.sv]
`timescale 1ns/1ps
module i2c_register_access_slave_tb;
  logic clock, resetn, addr_sel, cmd_valid, cmd_read, cmd_ready, done, nack, wr_strobe;
  logic [7:0] cmd_addr, cmd_index, cmd_data, rd_data, reg_index, wr_data, dev_rd;
  logic [7:0] regs [256];
  int bad_count, samples_checked;
  tws_if link ();
  tws_host #(.HALF(8)) i_tws_host (.clock(clock), .resetn(resetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_index(cmd_index),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .nack(nack), .rd_data(rd_data));
  tws_device i_tws_device (.clock(clock), .resetn(resetn), .link(link), .addr_sel(addr_sel),
    .wr_strobe(wr_strobe), .reg_index(reg_index), .wr_data(wr_data), .rd_data(dev_rd));
  tws_props i_tws_props (.clock(clock), .resetn(resetn), .scl(link.scl), .sda(link.sda),
    .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe));
  // ----------------------------------------
  // Register file behind the device
  // ----------------------------------------
  assign dev_rd = regs[reg_index];
  always @(posedge clock) if (wr_strobe) regs[reg_index] <= wr_data;
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task xfer(input logic rd, input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(negedge clock);
    {cmd_valid, cmd_read, cmd_addr, cmd_index, cmd_data} = {1'b1, rd, a, i, d};
    // Host is idle after done, so this edge takes the command
    @(posedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 9000) begin
        bad_count++;
        end_of_test;
      end
    end
    chk("ready", {7'h00, cmd_ready}, 8'h01);
  endtask
  task t_pair(input logic sel);
    logic [7:0] wa, ra;
    wa = {6'h1C, sel, 1'b0};
    ra = {6'h1C, sel, 1'b1};
    @(negedge clock);
    addr_sel = sel;
    xfer(1'b0, wa, 8'h0F, 8'hF0);
    chk("write nack", {7'h00, nack}, 8'h00);
    chk("reg 0F", regs[8'h0F], 8'hF0);
    xfer(1'b0, wa, 8'h80, 8'h01);
    xfer(1'b1, ra, 8'h0F, 8'h00);
    chk("read nack", {7'h00, nack}, 8'h00);
    chk("read 0F", rd_data, 8'hF0);
    xfer(1'b1, ra, 8'h80, 8'h00);
    chk("read 80", rd_data, 8'h01);
    $display("pair test %0d done", sel);
  endtask
  task t_foreign;
    @(negedge clock);
    addr_sel = 1'b0;
    xfer(1'b0, 8'h72, 8'h0F, 8'h11);
    chk("other pair nack", {7'h00, nack}, 8'h01);
    xfer(1'b0, 8'h5E, 8'h0F, 8'h22);
    chk("foreign nack", {7'h00, nack}, 8'h01);
    chk("reg kept", regs[8'h0F], 8'hF0);
    xfer(1'b1, 8'h73, 8'h0F, 8'h00);
    chk("other read nack", {7'h00, nack}, 8'h01);
    xfer(1'b1, 8'h71, 8'h0F, 8'h00);
    chk("recover read", rd_data, 8'hF0);
    $display("foreign test done");
  endtask
  initial begin
    {resetn, addr_sel, cmd_valid, cmd_read} = 4'h0;
    {cmd_addr, cmd_index, cmd_data} = 24'h000000;
    bad_count = 0;
    samples_checked = 0;
    foreach (regs[k]) regs[k] = 8'h00;
    repeat (4) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_pair(1'b0);
    t_pair(1'b1);
    t_foreign;
    end_of_test;
  end
endmodule
